// File: tb/ibd_decode_chk.sv
// Purpose: Port assertions for ibd_decode
// Assumes: Strobe vector order is dep, mem rd, mem wr, io rd, io wr, zero-length
// Notes:   Error checked only for its timing; its cause is judged by the bench
`timescale 1ns/1ns
module ibd_chk (
  // Clock, reset and captured beat
  input wire        clk, rst_n, in_valid, in_is_addr, in_dep_space, in_zero_len,
  input wire [2:0]  in_type,
  input wire [15:0] in_lanes, lane_enable_q,
  // Strobes and error
  input wire        dependent_space_line_read_strobe_q, mem_read_strobe_q,
  input wire        mem_write_strobe_q, io_read_strobe_q, io_write_strobe_q,
  input wire        zero_length_read_strobe_q, error_q
);
  wire [5:0] s = {dependent_space_line_read_strobe_q, mem_read_strobe_q, mem_write_strobe_q,
                  io_read_strobe_q, io_write_strobe_q, zero_length_read_strobe_q};
  wire       tk = in_valid && in_is_addr;
  wire       rd = tk && in_type == 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  sequence s_plain_rd; rd && !in_dep_space && !in_zero_len; endsequence
  sequence s_io_take; tk && (in_type == 3'h3 || in_type == 3'h4); endsequence
  property p_mrd; s_plain_rd |=> s == 6'h10; endproperty
  a_mrd: assert property (p_mrd) else $error("memory read strobe wrong");
  property p_dep; rd && in_dep_space && !in_zero_len |=> s == 6'h20; endproperty
  a_dep: assert property (p_dep) else $error("dependent read strobe wrong");
  property p_nomrd; rd && (in_dep_space || in_zero_len) |=> !mem_read_strobe_q; endproperty
  a_nomrd: assert property (p_nomrd) else $error("memory read strobe not held off");
  property p_zl; rd && in_zero_len |=> s == 6'h01; endproperty
  a_zl: assert property (p_zl) else $error("zero-length strobe wrong");
  property p_mwr; tk && in_type == 3'h2 |=> s == 6'h08; endproperty
  a_mwr: assert property (p_mwr) else $error("memory write strobe wrong");
  property p_io; s_io_take |=> |s[2:1] && lane_enable_q == $past(in_lanes); endproperty
  a_io: assert property (p_io) else $error("io strobe or lanes wrong");
  property p_lane0; !(|s[2:1]) |-> lane_enable_q == 16'h0000; endproperty
  a_lane0: assert property (p_lane0) else $error("lanes outside io beat");
  property p_idle; !tk |=> s == 6'h00 && $onehot0($past(s)); endproperty
  a_idle: assert property (p_idle) else $error("strobe without address beat");
  property p_err; error_q |-> $past(|s); endproperty
  a_err: assert property (p_err) else $error("error not one state after strobe");
endmodule
bind ibd_decode ibd_chk u_chk (.clk, .rst_n, .in_valid, .in_is_addr, .in_dep_space,
  .in_zero_len, .in_type, .in_lanes, .lane_enable_q, .dependent_space_line_read_strobe_q,
  .mem_read_strobe_q, .mem_write_strobe_q, .io_read_strobe_q, .io_write_strobe_q,
  .zero_length_read_strobe_q, .error_q);

// File: tb/ibd_rx.sv
// Purpose: Controller side receiver of the input bus
// Assumes: Same clock as the decoder
// Notes:   Lanes are only trusted while an io strobe is up
`timescale 1ns/1ns
module ibd_rx (
  // Clock and bus
  input  wire        clk, io_rd, io_wr, any_strobe, error_q,
  input  wire [15:0] lane_enable_q,
  // Observations
  output reg  [15:0] lanes_seen,
  output reg  [7:0]  err_seen
);
  reg strobe_q;
  initial begin
    lanes_seen = 16'h0000;
    err_seen = 8'h00;
    strobe_q = 1'b0;
  end
  always @(posedge clk) begin
    if (io_rd || io_wr) lanes_seen <= lane_enable_q;
    if (strobe_q && error_q) err_seen <= err_seen + 8'h01;
    strobe_q <= any_strobe;
  end
endmodule

// File: tb/test_ibd_decode.sv
// Purpose: Scenario bench for ibd_decode
// Assumes: Inputs change at rising edges by non-blocking assignment
// Notes:   Limits are fixed and both reached; parity sense is flipped once
`timescale 1ns/1ns
module test_ibd_decode;
  reg          clk, rst_n, v, ia, dp, zl, pr, po;
  reg  [2:0]   ty, rq;
  reg  [5:0]   tg;
  reg  [127:0] ad;
  reg  [15:0]  ln;
  wire [127:0] od;
  wire [15:0]  ol, seen;
  wire [2:0]   orq;
  wire [5:0]   otg, s;
  wire [7:0]   nerr;
  wire         er;
  integer      n_mismatch, checks;
  localparam [39:0] ML = 40'h00_0000_1000, IL = 40'h00_0000_0100;
  localparam [20:0] TT = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1};
  localparam [127:0] PAT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  ibd_decode dut (.clk(clk), .rst_n(rst_n), .in_valid(v), .in_is_addr(ia), .in_type(ty),
    .in_dep_space(dp), .in_zero_len(zl), .in_addr_data(ad), .in_lanes(ln),
    .in_requester(rq), .in_tag(tg), .in_parity(pr), .mem_limit(ML), .io_limit(IL),
    .parity_odd(po), .addr_data_q(od), .lane_enable_q(ol), .requester_tag_q(orq),
    .transaction_tag_q(otg), .dependent_space_line_read_strobe_q(s[5]),
    .mem_read_strobe_q(s[4]), .mem_write_strobe_q(s[3]), .io_read_strobe_q(s[2]),
    .io_write_strobe_q(s[1]), .zero_length_read_strobe_q(s[0]), .error_q(er));
  ibd_rx u_rx (.clk(clk), .io_rd(s[2]), .io_wr(s[1]), .any_strobe(|s), .error_q(er),
    .lane_enable_q(ol), .lanes_seen(seen), .err_seen(nerr));
  ////////////////////////////////////////////////////////////
  task cmp(input [127:0] g, input [127:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task beat(input [2:0] t, input d, input z, input [39:0] a, input p);
    begin
      v <= 1'b1;
      ia <= 1'b1;
      ty <= t;
      dp <= d;
      zl <= z;
      ad <= {64'h0, a, 24'h0};
      pr <= p;
    end
  endtask
  function [5:0] ex(input [2:0] t, input d, input z);
    case (t)
      3'h1: ex = z ? 6'h01 : (d ? 6'h20 : 6'h10);
      3'h2: ex = 6'h08;
      3'h3: ex = 6'h04;
      3'h4: ex = 6'h02;
      default: ex = 6'h00;
    endcase
  endfunction
  task end_of_test;
    begin
      if (n_mismatch == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Every strobe type and code 5 back to back, results checked one cycle behind the drive
  task t_types;
    reg [2:0] pt, pk;
    reg       pd, pz;
    integer   k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        @(posedge clk);
        if (k < 7) beat(TT[k*3+:3], k == 1, k == 2, 40'h10 + k, ^(40'h10 + k));
        else v <= 1'b0;
        ln <= 16'ha500 | k[2:0];
        rq <= k[2:0];
        tg <= {k[2:0], 3'h5};
        #1;
        if (k > 0) begin
          cmp(s, ex(pt, pd, pz));
          cmp(od, {64'h0, 37'h2, pk, 24'h0});
          cmp(ol, (pt == 3'h3 || pt == 3'h4) ? (16'ha500 | pk) : 16'h0);
          cmp({orq, otg}, {pk, pk, 3'h5});
        end
        pt = TT[k*3+:3];
        pd = k == 1;
        pz = k == 2;
        pk = k[2:0];
      end
      cmp(seen, 16'ha505);
    end
  endtask
  // Strobe first, error only in the following state
  task err1(input [2:0] t, input [39:0] a, input p, input e);
    begin
      @(posedge clk);
      beat(t, 1'b0, 1'b0, a, p);
      @(posedge clk);
      v <= 1'b0;
      #1 cmp(|s, 1'b1);
      cmp(er, 1'b0);
      @(posedge clk);
      #1 cmp(er, e);
    end
  endtask
  task t_err;
    begin
      err1(3'h1, ML, ^ML, 1'b1);
      err1(3'h3, 40'h20, ~^40'h20, 1'b1);
      err1(3'h2, ML - 40'h1, ^(ML - 40'h1), 1'b0);
      err1(3'h4, IL, ^IL, 1'b1);
      // Odd sense turns a parity that is good under even into a failure
      @(posedge clk);
      po <= 1'b1;
      err1(3'h2, 40'h40, ^40'h40, 1'b1);
      // The receiver counts the last error one edge after it stands
      @(posedge clk);
      po <= 1'b0;
      #1 cmp(nerr, 8'h04);
    end
  endtask
  // Data beat moves the word but strobes nothing; an idle cycle moves nothing
  task t_refuse;
    begin
      @(posedge clk);
      v <= 1'b1;
      ia <= 1'b0;
      ty <= 3'h1;
      ad <= PAT;
      @(posedge clk);
      v <= 1'b0;
      ia <= 1'b1;
      ad <= 128'h0;
      #1 cmp(s, 6'h00);
      cmp(od, PAT);
      @(posedge clk);
      #1 cmp(s, 6'h00);
      cmp(od, PAT);
    end
  endtask
  // Zero length beats dependent space; a mid-run reset clears all in flight
  task t_reset;
    begin
      @(posedge clk);
      beat(3'h1, 1'b1, 1'b1, 40'h30, ^40'h30);
      @(posedge clk);
      beat(3'h4, 1'b0, 1'b0, IL, ^IL);
      #1 cmp(s, ex(3'h1, 1'b1, 1'b1));
      @(posedge clk);
      v <= 1'b0;
      rst_n <= 1'b0;
      #1 cmp(od, 128'h0);
      cmp({ol, orq, otg, s, er}, 32'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 cmp({ol, s, er}, 23'h0);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_n, v, ia, dp, zl, pr, po, ty, rq, tg, ad, ln} = 0;
    n_mismatch = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_types;
    t_err;
    t_refuse;
    t_reset;
    end_of_test;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
endmodule

// File: verilog/ibd_check.v
// Purpose: Range and parity check of a captured address, one state late
// Assumes: Same clock as the decoder
// Notes:   Error is registered so it lands one state after the strobe
`timescale 1ns/1ns
`include "ibd_regs.vh"
module ibd_check #(
  parameter LIMIT_W = 40
) (
  // Clock and reset
  input  wire               clk,
  input  wire               rst_n,
  // Check request
  input  wire               chk_en,
  input  wire [LIMIT_W-1:0] addr,
  input  wire [LIMIT_W-1:0] limit,
  input  wire               par_in,
  input  wire               par_odd,
  // Result
  output reg                err_q
);
  wire fail;
  // Range fails at or above the limit; parity uses the chosen sense
  assign fail = (addr >= limit) | ((^addr) ^ par_in ^ par_odd);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= chk_en & fail;
    end
  end
endmodule

// File: verilog/ibd_decode.v
// Purpose: Input bus presenting captured words with one-hot type strobes
// Assumes: Capture logic on the same clock supplies one beat per cycle
//          Type codes are known whenever the address marker is high
//          Limits and parity sense change only while the bus is idle
// Notes:   Strobes are never held back for checking; the error lags by one
//          Zero length takes precedence when a read is also marked dependent
//          Range uses the io limit on io beats and the memory limit otherwise
//          Parity covers only the gathered address, never the data lanes
//          No stall exists: a beat is taken every cycle it is offered
//          Data and tags hold until the next valid beat; strobes pulse once
//          Codes 5 to 7 and code 0 are treated as no transaction
//          Reset clears every output, including a strobe or error in flight
//          LIMIT_W above forty would need a wider gathered address
//
// How it works
// - Drive 128-bit bus; address in five lanes
// - Sixteen lane qualifiers, meaningful for I/O only
// - Lane qualifiers valid only with I/O strobes
// - Three-bit requester tag follows the bus
// - Six-bit transaction tag follows the bus
// - Dependent-space memory read gets own strobe
// - Memory read strobe on memory read address
// - No memory read strobe for dependent, zero-length
// - Memory write strobe on memory write address
// - Strobes raised before range or parity check
// - Error flag follows strobe by one state
// - I/O read and write strobes on I/O addresses
// - Zero-length read gets its own strobe
`timescale 1ns/1ns
`include "ibd_regs.vh"
module ibd_decode #(
  parameter LIMIT_W = 40
) (
  // Clock and reset
  input  wire                      clk,
  input  wire                      rst_n,
  // Captured beat from the bus pads logic
  input  wire                      in_valid,
  input  wire                      in_is_addr,
  input  wire [`IBD_TYPE_W-1:0]    in_type,
  input  wire                      in_dep_space,
  input  wire                      in_zero_len,
  input  wire [`IBD_DATA_W-1:0]    in_addr_data,
  input  wire [`IBD_LANES_W-1:0]   in_lanes,
  input  wire [`IBD_REQ_W-1:0]     in_requester,
  input  wire [`IBD_TAG_W-1:0]     in_tag,
  input  wire                      in_parity,
  // Check configuration
  input  wire [LIMIT_W-1:0]        mem_limit,
  input  wire [LIMIT_W-1:0]        io_limit,
  input  wire                      parity_odd,
  // Input bus to the controllers
  output reg  [`IBD_DATA_W-1:0]    addr_data_q,
  output reg  [`IBD_LANES_W-1:0]   lane_enable_q,
  output reg  [`IBD_REQ_W-1:0]     requester_tag_q,
  output reg  [`IBD_TAG_W-1:0]     transaction_tag_q,
  // Type strobes and error
  output reg                       dependent_space_line_read_strobe_q,
  output reg                       mem_read_strobe_q,
  output reg                       mem_write_strobe_q,
  output reg                       io_read_strobe_q,
  output reg                       io_write_strobe_q,
  output reg                       zero_length_read_strobe_q,
  output wire                      error_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the incoming beat
  // Gathered address width; the check may use fewer low bits
  localparam ADDR_W = `IBD_ADDR_LANES * 8;
  reg             dep_d;
  reg             mrd_d;
  reg             mwr_d;
  reg             iord_d;
  reg             iowr_d;
  reg             zlr_d;
  wire            addr_beat;
  wire            any_strobe;
  wire            is_io;
  wire [ADDR_W-1:0] addr_word;

  // Only address beats are decoded; data beats go straight to the bus
  assign addr_beat = in_valid & in_is_addr;

  // One case arm per type and one read branch of three, so at most one strobe
  always @* begin
    dep_d  = 1'b0;
    mrd_d  = 1'b0;
    mwr_d  = 1'b0;
    iord_d = 1'b0;
    iowr_d = 1'b0;
    zlr_d  = 1'b0;
    if (addr_beat) begin
      case (in_type)
        `IBD_T_MEM_RD: begin
          // Zero length wins over dependent space so only one strobe fires
          if (in_zero_len) begin
            zlr_d = 1'b1;
          end else if (in_dep_space) begin
            dep_d = 1'b1;
          end else begin
            mrd_d = 1'b1;
          end
        end
        `IBD_T_MEM_WR: begin
          mwr_d = 1'b1;
        end
        `IBD_T_IO_RD: begin
          iord_d = 1'b1;
        end
        `IBD_T_IO_WR: begin
          iowr_d = 1'b1;
        end
        default: begin
          // Other codes raise no strobe
          dep_d = 1'b0;
        end
      endcase
    end
  end

  // Any strobe starts a check one stage later
  assign any_strobe = dep_d | mrd_d | mwr_d | iord_d | iowr_d | zlr_d;
  assign is_io      = iord_d | iowr_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address gathered from its five byte lanes
  // Bus byte lane 3 + g carries byte g of the address
  genvar g;
  generate
    for (g = 0; g < `IBD_ADDR_LANES; g = g + 1) begin : g_lane
      assign addr_word[g*8 +: 8] = in_addr_data[`IBD_ADDR_LANE0 + g*8 +: 8];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data and tags follow every valid beat, address or data alike
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_data_q       <= {`IBD_DATA_W{1'b0}};
      requester_tag_q   <= {`IBD_REQ_W{1'b0}};
      transaction_tag_q <= {`IBD_TAG_W{1'b0}};
    end else if (in_valid) begin
      addr_data_q       <= in_addr_data;
      requester_tag_q   <= in_requester;
      transaction_tag_q <= in_tag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lanes zeroed outside I/O beats so stale enables never leak
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_enable_q <= {`IBD_LANES_W{1'b0}};
    end else begin
      lane_enable_q <= is_io ? in_lanes : {`IBD_LANES_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes go out the same cycle as their address and never wait for the check
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dependent_space_line_read_strobe_q <= 1'b0;
      mem_read_strobe_q                  <= 1'b0;
      mem_write_strobe_q                 <= 1'b0;
      io_read_strobe_q                   <= 1'b0;
      io_write_strobe_q                  <= 1'b0;
      zero_length_read_strobe_q          <= 1'b0;
    end else begin
      dependent_space_line_read_strobe_q <= dep_d;
      mem_read_strobe_q                  <= mrd_d;
      mem_write_strobe_q                 <= mwr_d;
      io_read_strobe_q                   <= iord_d;
      io_write_strobe_q                  <= iowr_d;
      zero_length_read_strobe_q          <= zlr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Check runs on the strobe's cycle and reports one state later
  // The compare and parity tree sit a stage behind the strobe to keep the
  // strobe path short; the price is an error that arrives one state late
  reg             chk_en_q;
  reg             chk_io_q;
  reg             par_q;
  reg [LIMIT_W-1:0] chk_addr_q;
  wire [LIMIT_W-1:0] chk_limit;

  // Capture what the check needs from the strobed beat
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_en_q   <= 1'b0;
      chk_io_q   <= 1'b0;
      par_q      <= 1'b0;
      chk_addr_q <= {LIMIT_W{1'b0}};
    end else begin
      chk_en_q   <= any_strobe;
      chk_io_q   <= is_io;
      par_q      <= in_parity;
      chk_addr_q <= addr_word[LIMIT_W-1:0];
    end
  end

  // Io beats are judged against the io window, all others against memory
  assign chk_limit = chk_io_q ? io_limit : mem_limit;

  // Error comes straight from the check's own flip-flop
  ibd_check #(
    .LIMIT_W (LIMIT_W)
  ) u_check (
    .clk     (clk),
    .rst_n   (rst_n),
    .chk_en  (chk_en_q),
    .addr    (chk_addr_q),
    .limit   (chk_limit),
    .par_in  (par_q),
    .par_odd (parity_odd),
    .err_q   (error_q)
  );

endmodule

// File: verilog/ibd_regs.vh
// Purpose: Constants for the input bus decode strobes block
// Assumes: Included by bare name
// Notes:   Transaction type codes are local to the capture port
`ifndef IBD_REGS_VH
`define IBD_REGS_VH
`define IBD_DATA_W      128
`define IBD_LANES_W     16
`define IBD_REQ_W       3
`define IBD_TAG_W       6
`define IBD_TYPE_W      3
// Transaction type codes presented by the capture logic
`define IBD_T_NONE      3'h0
`define IBD_T_MEM_RD    3'h1
`define IBD_T_MEM_WR    3'h2
`define IBD_T_IO_RD     3'h3
`define IBD_T_IO_WR     3'h4
`define IBD_T_OTHER     3'h5
// Address byte lanes: lowest bit of the first of the five lanes, and their count
`define IBD_ADDR_LANE0  24
`define IBD_ADDR_LANES  5
`endif
